// *** hdl/fbcmd_cfg.svh ***
`ifndef FBCMD_CFG_SVH
`define FBCMD_CFG_SVH
// Behaviour
// - command bit 0 runs or stops drive
// - command bit 1 requests fast stop
// - command bit 2 resets a tripped drive
// - command bit 3 requests coast stop
// - priority coast, then fast, then run
// - stop bits act only for source 0/1
// - reset bit honoured in modes 3 and 4
// - speed reference in 0.1 Hz units
// - speed reference clamped to speed limit
// - ramp applies only in mode 4
// - ramp loads acceleration and deceleration together
// - status high byte holds fault when tripped
// - status bits running, tripped, standby
// - ready bit: untripped, enabled, mains present
// - heartbeat period, 1 ms units, default zero
// - emergency inhibit, 100 us units, default zero
// - transmit pdo inhibit spacing, 100 us units
// - transmit comm records, three entries, defaults
// - sdo identifiers read only, node based
// - mapping records four entries with defaults
// - identity record four read-only entries
// - receive pdo sync or immediate by type
// - type 254 transmit follows receive pdo
// - all objects return to defaults at power-up
// - expedited access only, segmented refused

// ************
// object indexes
// ************
`define IDX_DEVICE_TYPE 16'h1000
`define IDX_ERROR_FLAGS 16'h1001
`define IDX_MAKER_STATUS 16'h1002
`define IDX_SYNC_ID 16'h1005
`define IDX_GUARD 16'h100c
`define IDX_LIFE 16'h100d
`define IDX_EMCY_ID 16'h1014
`define IDX_EMCY_INH 16'h1015
`define IDX_HEARTBEAT 16'h1017
`define IDX_IDENTITY 16'h1018
`define IDX_SDO 16'h1200
`define IDX_RX_COMM0 16'h1400
`define IDX_RX_COMM1 16'h1401
`define IDX_RX_MAP0 16'h1600
`define IDX_RX_MAP1 16'h1601
`define IDX_TX_COMM0 16'h1800
`define IDX_TX_COMM1 16'h1801
`define IDX_TX_MAP0 16'h1a00
`define IDX_TX_MAP1 16'h1a01
`define IDX_CMD_WORD 16'h2000
`define IDX_SPEED_REF 16'h2001
`define IDX_RAMP_TIME 16'h2003
`define IDX_STATUS_WORD 16'h200a

// ************
// reset values
// ************
`define DEF_DEVICE_TYPE 32'h0000_0000
`define DEF_SYNC_ID 32'h0000_0080
`define DEF_EMCY_BASE 32'h0000_0080
`define DEF_SDO_RX_BASE 32'h0000_0600
`define DEF_SDO_TX_BASE 32'h0000_0580
`define DEF_RX0_COB 32'h4000_0200
`define DEF_RX1_COB 32'hc000_0300
`define DEF_TX0_COB 32'h4000_0180
`define DEF_TX1_COB 32'hc000_0280
`define DEF_RX_TYPE 8'hfe
`define DEF_TX0_TYPE 8'hfe
`define DEF_TX1_TYPE 8'h00
`define MAP_DUMMY 32'h0006_0010
`define MAP_RX0_E0 32'h2000_0010
`define MAP_RX0_E1 32'h2001_0010
`define MAP_RX0_E2 32'h2003_0010
`define MAP_TX0_E0 32'h200a_0010
`define MAP_TX0_E1 32'h200b_0010
`define MAP_TX0_E2 32'h200d_0010
`define MAP_TX0_E3 32'h2010_0010
`define MAP_TX1_E0 32'h2011_0010
`define MAP_TX1_E1 32'h2012_0010
`define MAP_TX1_E2 32'h2013_0010
`define MAP_TX1_E3 32'h2014_0010
`define MAP_SLOT_BITS 8'h10
`define RX_SYNC_MAX 8'hf0
`define TYPE_ON_RX 8'hfe
`define TYPE_ON_CHANGE 8'hff

// ************
// timing
// ************
`define CLK_PERIOD_NS 50
`define INH_UNIT_NS 100000
`define INH_UNIT_CYCLES (`INH_UNIT_NS / `CLK_PERIOD_NS)
`define HB_UNIT_NS 1000000
`define HB_UNIT_CYCLES (`HB_UNIT_NS / `CLK_PERIOD_NS)

`endif

// *** hdl/fbcmd_pkg.sv ***
`default_nettype none
package fbcmd_pkg;
	// one object dictionary access from the sdo server
	typedef struct packed {
		logic        write;
		logic        segmented;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] data;
	} od_req_t;
	// condition reported by the motor stage
	typedef struct packed {
		logic       running;
		logic       tripped;
		logic       standby;
		logic       hw_enable;
		logic       mains_loss;
		logic [7:0] fault_code;
	} drive_state_t;
endpackage
`default_nettype wire

// *** hdl/fieldbus_drive_command_slave.sv ***
`include "fbcmd_cfg.svh"
`default_nettype none
module fieldbus_drive_command_slave
	import fbcmd_pkg::*;
#(
	parameter int          HB_UNIT_CYCLES = `HB_UNIT_CYCLES,
	parameter logic [31:0] VENDOR_CODE    = 32'h0000_0abc, // arbitrary value
	parameter logic [31:0] PRODUCT_CODE   = 32'h0000_0001, // arbitrary value
	parameter logic [31:0] REVISION_CODE  = 32'h0000_0001, // arbitrary value
	parameter logic [31:0] SERIAL_CODE    = 32'h0000_0001  // arbitrary value
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_n_in,
	input  wire logic [6:0]   node_id_in,
	input  wire logic [7:0]   run_source_in,
	input  wire logic [7:0]   control_mode_in,
	input  wire logic [15:0]  speed_limit_in,
	input  wire drive_state_t drive_state_in,
	input  wire logic         od_req_valid_in,
	input  wire od_req_t      od_req_in,
	output logic              od_ack_out,
	output logic              od_abort_out,
	output logic [31:0]       od_rdata_out,
	input  wire logic         rpdo_valid_in,
	input  wire logic         rpdo_sel_in,
	input  wire logic [63:0]  rpdo_data_in,
	input  wire logic         sync_in,
	output logic              run_out,
	output logic              fast_stop_out,
	output logic              coast_stop_out,
	output logic              trip_reset_out,
	output logic [15:0]       speed_ref_out,
	output logic [15:0]       accel_ramp_out,
	output logic [15:0]       decel_ramp_out,
	output logic [15:0]       status_word_out,
	output logic [1:0]        tpdo_send_out,
	output logic              heartbeat_out
);

	// ************
	// helpers
	// ************
	// mapping entry: index 31:16, sub 15:8, length 7:0
	function automatic logic slot_is(input logic [31:0] m, input logic [15:0] idx);
		slot_is = (m[31:16] == idx) && (m[7:0] == `MAP_SLOT_BITS);
	endfunction

	// {hit, record} for the four mapping records
	function automatic logic [2:0] map_slot(input logic [15:0] idx);
		case (idx)
			`IDX_RX_MAP0: map_slot = 3'h4;
			`IDX_RX_MAP1: map_slot = 3'h5;
			`IDX_TX_MAP0: map_slot = 3'h6;
			`IDX_TX_MAP1: map_slot = 3'h7;
			default:      map_slot = 3'h0;
		endcase
	endfunction

	function automatic logic [31:0] map_default(input logic [3:0] pk);
		case (pk)
			4'h0:    map_default = `MAP_RX0_E0;
			4'h1:    map_default = `MAP_RX0_E1;
			4'h2:    map_default = `MAP_RX0_E2;
			4'h8:    map_default = `MAP_TX0_E0;
			4'h9:    map_default = `MAP_TX0_E1;
			4'ha:    map_default = `MAP_TX0_E2;
			4'hb:    map_default = `MAP_TX0_E3;
			4'hc:    map_default = `MAP_TX1_E0;
			4'hd:    map_default = `MAP_TX1_E1;
			4'he:    map_default = `MAP_TX1_E2;
			4'hf:    map_default = `MAP_TX1_E3;
			default: map_default = `MAP_DUMMY;
		endcase
	endfunction

	// ************
	// storage
	// ************
	logic        init_reg;
	logic [31:0] sync_id_reg;
	logic [15:0] guard_reg;
	logic [7:0]  life_reg;
	logic [31:0] emcy_id_reg;
	logic [15:0] emcy_inh_reg;
	logic [15:0] hb_period_reg;
	logic [31:0] rx_cob_reg [2];
	logic [7:0]  rx_type_reg [2];
	logic [31:0] tx_cob_reg [2];
	logic [7:0]  tx_type_reg [2];
	logic [15:0] tx_inh_reg [2];
	logic [31:0] map_reg [4][4];
	logic [15:0] cmd_reg;
	logic [15:0] speed_reg;
	logic [15:0] ramp_reg;

	od_req_t     rq;
	logic [2:0]  msel;
	logic [1:0]  sub_ix;
	logic [31:0] node32;
	logic        sub0;
	logic        hit;
	logic        wr_ok;
	logic [31:0] rd_val;
	logic        wr_en;
	logic        bad;

	assign rq     = od_req_in;
	assign msel   = map_slot(rq.index);
	assign sub_ix = 2'(rq.sub - 8'h01);
	assign node32 = {25'h0, node_id_in};
	assign sub0   = (rq.sub == 8'h00);

	// ************
	// object read and access decode
	// ************
	always_comb begin
		rd_val = 32'h0;
		hit = sub0;
		wr_ok = 1'b0;
		case (rq.index)
			`IDX_DEVICE_TYPE:  rd_val = `DEF_DEVICE_TYPE;
			`IDX_ERROR_FLAGS:  rd_val = {31'h0, drive_state_in.tripped};
			`IDX_MAKER_STATUS: rd_val = {16'h0, status_word_out};
			`IDX_SYNC_ID: begin
				rd_val = sync_id_reg;
				wr_ok = 1'b1;
			end
			`IDX_GUARD: begin
				rd_val = {16'h0, guard_reg};
				wr_ok = 1'b1;
			end
			`IDX_LIFE: begin
				rd_val = {24'h0, life_reg};
				wr_ok = 1'b1;
			end
			`IDX_EMCY_ID: begin
				rd_val = emcy_id_reg;
				wr_ok = 1'b1;
			end
			`IDX_EMCY_INH: begin
				rd_val = {16'h0, emcy_inh_reg};
				wr_ok = 1'b1;
			end
			`IDX_HEARTBEAT: begin
				rd_val = {16'h0, hb_period_reg};
				wr_ok = 1'b1;
			end
			`IDX_IDENTITY: begin
				hit = (rq.sub <= 8'h04);
				case (rq.sub)
					8'h00:   rd_val = 32'h4;
					8'h01:   rd_val = VENDOR_CODE;
					8'h02:   rd_val = PRODUCT_CODE;
					8'h03:   rd_val = REVISION_CODE;
					default: rd_val = SERIAL_CODE;
				endcase
			end
			`IDX_SDO: begin
				hit = (rq.sub <= 8'h02);
				case (rq.sub)
					8'h00:   rd_val = 32'h2;
					8'h01:   rd_val = `DEF_SDO_RX_BASE + node32;
					default: rd_val = `DEF_SDO_TX_BASE + node32;
				endcase
			end
			`IDX_RX_COMM0, `IDX_RX_COMM1: begin
				hit = (rq.sub <= 8'h02);
				wr_ok = !sub0;
				case (rq.sub)
					8'h00:   rd_val = 32'h2;
					8'h01:   rd_val = rx_cob_reg[rq.index[0]];
					default: rd_val = {24'h0, rx_type_reg[rq.index[0]]};
				endcase
			end
			`IDX_TX_COMM0, `IDX_TX_COMM1: begin
				hit = (rq.sub <= 8'h03);
				wr_ok = !sub0;
				case (rq.sub)
					8'h00:   rd_val = 32'h3;
					8'h01:   rd_val = tx_cob_reg[rq.index[0]];
					8'h02:   rd_val = {24'h0, tx_type_reg[rq.index[0]]};
					default: rd_val = {16'h0, tx_inh_reg[rq.index[0]]};
				endcase
			end
			`IDX_CMD_WORD:    rd_val = {16'h0, cmd_reg};
			`IDX_SPEED_REF:   rd_val = {16'h0, speed_ref_out};
			`IDX_RAMP_TIME:   rd_val = {16'h0, ramp_reg};
			`IDX_STATUS_WORD: rd_val = {16'h0, status_word_out};
			default: begin
				hit = msel[2] && (rq.sub <= 8'h04);
				wr_ok = !sub0;
				rd_val = sub0 ? 32'h4 : map_reg[msel[1:0]][sub_ix];
			end
		endcase
	end

	// segmented transfers and writes to read-only objects are aborted
	assign bad   = !hit || rq.segmented || (rq.write && !wr_ok);
	assign wr_en = od_req_valid_in && init_reg && !bad && rq.write;

	// answer one cycle after the request
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			od_ack_out <= 1'b0;
			od_abort_out <= 1'b0;
			od_rdata_out <= 32'h0;
		end else begin
			od_ack_out <= od_req_valid_in;
			od_abort_out <= od_req_valid_in && (bad || !init_reg);
			od_rdata_out <= (od_req_valid_in && !bad && !rq.write) ? rd_val : 32'h0;
		end
	end

	// ************
	// configuration objects
	// ************
	// node based identifiers load on the first edge after reset
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			init_reg <= 1'b0;
			sync_id_reg <= `DEF_SYNC_ID;
			guard_reg <= 16'h0;
			life_reg <= 8'h0;
			emcy_id_reg <= 32'h0;
			emcy_inh_reg <= 16'h0;
			hb_period_reg <= 16'h0;
			for (int p = 0; p < 2; p++) begin
				rx_cob_reg[p] <= 32'h0;
				rx_type_reg[p] <= `DEF_RX_TYPE;
				tx_cob_reg[p] <= 32'h0;
				tx_inh_reg[p] <= 16'h0;
			end
			tx_type_reg[0] <= `DEF_TX0_TYPE;
			tx_type_reg[1] <= `DEF_TX1_TYPE;
			for (int p = 0; p < 4; p++) begin
				for (int k = 0; k < 4; k++) begin
					map_reg[p][k] <= map_default(4'(p * 4 + k));
				end
			end
		end else if (!init_reg) begin
			init_reg <= 1'b1;
			emcy_id_reg <= `DEF_EMCY_BASE + node32;
			rx_cob_reg[0] <= `DEF_RX0_COB + node32;
			rx_cob_reg[1] <= `DEF_RX1_COB + node32;
			tx_cob_reg[0] <= `DEF_TX0_COB + node32;
			tx_cob_reg[1] <= `DEF_TX1_COB + node32;
		end else if (wr_en) begin
			case (rq.index)
				`IDX_SYNC_ID:   sync_id_reg <= rq.data;
				`IDX_GUARD:     guard_reg <= rq.data[15:0];
				`IDX_LIFE:      life_reg <= rq.data[7:0];
				`IDX_EMCY_ID:   emcy_id_reg <= rq.data;
				`IDX_EMCY_INH:  emcy_inh_reg <= rq.data[15:0];
				`IDX_HEARTBEAT: hb_period_reg <= rq.data[15:0];
				`IDX_RX_COMM0, `IDX_RX_COMM1: begin
					if (rq.sub == 8'h01) rx_cob_reg[rq.index[0]] <= rq.data;
					else rx_type_reg[rq.index[0]] <= rq.data[7:0];
				end
				`IDX_TX_COMM0, `IDX_TX_COMM1: begin
					if (rq.sub == 8'h01) tx_cob_reg[rq.index[0]] <= rq.data;
					else if (rq.sub == 8'h02) tx_type_reg[rq.index[0]] <= rq.data[7:0];
					else tx_inh_reg[rq.index[0]] <= rq.data[15:0];
				end
				default: map_reg[msel[1:0]][sub_ix] <= rq.data;
			endcase
		end
	end

	// ************
	// receive pdo staging and apply
	// ************
	logic [1:0]  rx_hit;
	logic [1:0]  rx_sync;
	logic [1:0]  src_valid;
	logic [63:0] src_data [2];
	logic [1:0]  pend_reg;
	logic [63:0] pend_data_reg [2];
	logic [15:0] cmd_next;
	logic [15:0] speed_next;
	logic [15:0] ramp_next;
	logic        ramp_hit;

	// sync types wait for the next sync, 254/255 apply at once
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			rx_hit[p] = rpdo_valid_in && (rpdo_sel_in == 1'(p)) && !rx_cob_reg[p][31];
			rx_sync[p] = (rx_type_reg[p] <= `RX_SYNC_MAX);
			src_valid[p] = (rx_hit[p] && !rx_sync[p]) || (sync_in && pend_reg[p]);
			src_data[p] = (rx_hit[p] && !rx_sync[p]) ? rpdo_data_in : pend_data_reg[p];
		end
	end

	// a new frame arriving with sync stays pending for the next one
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_reg <= 2'h0;
			pend_data_reg[0] <= 64'h0;
			pend_data_reg[1] <= 64'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (rx_hit[p] && rx_sync[p]) begin
					pend_reg[p] <= 1'b1;
					pend_data_reg[p] <= rpdo_data_in;
				end else if (sync_in) begin
					pend_reg[p] <= 1'b0;
				end
			end
		end
	end

	// route each mapped 16-bit slot to its object
	always_comb begin
		cmd_next = cmd_reg;
		speed_next = speed_reg;
		ramp_next = ramp_reg;
		ramp_hit = 1'b0;
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 4; k++) begin
				if (src_valid[p] && slot_is(map_reg[p][k], `IDX_CMD_WORD)) cmd_next = src_data[p][16 * k +: 16];
				if (src_valid[p] && slot_is(map_reg[p][k], `IDX_SPEED_REF)) speed_next = src_data[p][16 * k +: 16];
				if (src_valid[p] && slot_is(map_reg[p][k], `IDX_RAMP_TIME)) begin
					ramp_next = src_data[p][16 * k +: 16];
					ramp_hit = 1'b1;
				end
			end
		end
	end

	// ************
	// drive commands
	// ************
	logic               src_ok;
	logic               mode_ok;
	logic signed [16:0] spd_s;
	logic signed [16:0] lim_s;
	logic [15:0]        spd_clamped;
	logic               ready;
	logic [15:0]        status_next;

	assign src_ok  = (run_source_in == 8'h00) || (run_source_in == 8'h01);
	assign mode_ok = (control_mode_in == 8'h03) || (control_mode_in == 8'h04);
	assign spd_s   = {speed_reg[15], speed_reg};
	assign lim_s   = {1'b0, speed_limit_in};
	// speed stays in 0.1 Hz steps, limited both ways
	assign spd_clamped = (spd_s > lim_s) ? speed_limit_in :
		(spd_s < -lim_s) ? 16'(-lim_s) : speed_reg;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_reg <= 16'h0;
			speed_reg <= 16'h0;
			ramp_reg <= 16'h0;
			accel_ramp_out <= 16'h0;
			decel_ramp_out <= 16'h0;
		end else begin
			cmd_reg <= cmd_next;
			speed_reg <= speed_next;
			ramp_reg <= ramp_next;
			if (ramp_hit && control_mode_in == 8'h04) begin
				accel_ramp_out <= ramp_next;
				decel_ramp_out <= ramp_next;
			end
		end
	end

	// coast over fast stop over run
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			coast_stop_out <= 1'b0;
			fast_stop_out <= 1'b0;
			run_out <= 1'b0;
			trip_reset_out <= 1'b0;
			speed_ref_out <= 16'h0;
		end else begin
			coast_stop_out <= src_ok && cmd_reg[3];
			fast_stop_out <= src_ok && cmd_reg[1] && !cmd_reg[3];
			run_out <= src_ok && cmd_reg[0] && !cmd_reg[1] && !cmd_reg[3];
			trip_reset_out <= mode_ok && cmd_reg[2] && drive_state_in.tripped;
			speed_ref_out <= spd_clamped;
		end
	end

	// ************
	// status word
	// ************
	assign ready = !drive_state_in.tripped && drive_state_in.hw_enable && !drive_state_in.mains_loss;
	assign status_next = {drive_state_in.tripped ? drive_state_in.fault_code : 8'h0,
		1'b0, ready, drive_state_in.standby, 3'h0,
		drive_state_in.tripped, drive_state_in.running};

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) status_word_out <= 16'h0;
		else status_word_out <= status_next;
	end

	// ************
	// transmit pdo scheduling
	// ************
	logic [10:0] inh_pre_reg;
	logic        inh_tick;
	logic        stat_chg;
	logic [1:0]  trig;
	logic [1:0]  send;
	logic [1:0]  txp_reg;
	logic [1:0]  chg_reg;
	logic [7:0]  sync_cnt_reg [2];
	logic [16:0] inh_cnt_reg [2];

	assign inh_tick = (inh_pre_reg == 11'(`INH_UNIT_CYCLES - 1));
	assign stat_chg = (status_next != status_word_out);

	always_comb begin
		for (int n = 0; n < 2; n++) begin
			case (tx_type_reg[n])
				`TYPE_ON_RX:     trig[n] = rx_hit[n];
				`TYPE_ON_CHANGE: trig[n] = stat_chg;
				8'h00:           trig[n] = sync_in && chg_reg[n];
				default:         trig[n] = sync_in && (tx_type_reg[n] <= `RX_SYNC_MAX)
					&& (sync_cnt_reg[n] + 8'h01 >= tx_type_reg[n]);
			endcase
			trig[n] = trig[n] && !tx_cob_reg[n][31];
			send[n] = txp_reg[n] && (inh_cnt_reg[n] == 17'h0);
		end
	end

	// pending send waits out the inhibit spacing
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			inh_pre_reg <= 11'h0;
			txp_reg <= 2'h0;
			chg_reg <= 2'h0;
			tpdo_send_out <= 2'h0;
			for (int n = 0; n < 2; n++) begin
				sync_cnt_reg[n] <= 8'h0;
				inh_cnt_reg[n] <= 17'h0;
			end
		end else begin
			inh_pre_reg <= inh_tick ? 11'h0 : inh_pre_reg + 11'h1;
			tpdo_send_out <= send;
			for (int n = 0; n < 2; n++) begin
				txp_reg[n] <= trig[n] || (txp_reg[n] && !send[n]);
				chg_reg[n] <= stat_chg || (chg_reg[n] && !send[n]);
				if (sync_in) sync_cnt_reg[n] <= (sync_cnt_reg[n] + 8'h01 >= tx_type_reg[n]) ? 8'h0 : sync_cnt_reg[n] + 8'h01;
				if (send[n]) inh_cnt_reg[n] <= (tx_inh_reg[n] == 16'h0) ? 17'h0 : {1'b0, tx_inh_reg[n]} + 17'h1;
				else if (inh_tick && inh_cnt_reg[n] != 17'h0) inh_cnt_reg[n] <= inh_cnt_reg[n] - 17'h1;
			end
		end
	end

	// ************
	// heartbeat producer
	// ************
	logic [14:0] ms_pre_reg;
	logic [15:0] hb_cnt_reg;
	logic        ms_tick;

	assign ms_tick = (ms_pre_reg == 15'(HB_UNIT_CYCLES - 1));

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ms_pre_reg <= 15'h0;
			hb_cnt_reg <= 16'h0;
			heartbeat_out <= 1'b0;
		end else begin
			ms_pre_reg <= ms_tick ? 15'h0 : ms_pre_reg + 15'h1;
			heartbeat_out <= 1'b0;
			if (hb_period_reg == 16'h0) begin
				hb_cnt_reg <= 16'h0;
			end else if (ms_tick) begin
				if (hb_cnt_reg + 16'h1 >= hb_period_reg) begin
					hb_cnt_reg <= 16'h0;
					heartbeat_out <= 1'b1;
				end else begin
					hb_cnt_reg <= hb_cnt_reg + 16'h1;
				end
			end
		end
	end

	// ************
	// checks
	// ************
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_coast_priority: assert property (coast_stop_out |-> !run_out && !fast_stop_out)
		else $error("coast stop not exclusive");
	a_source_gate: assert property ((run_out || fast_stop_out || coast_stop_out) |-> $past(src_ok))
		else $error("command acted outside run source 0 or 1");
	a_run_follows: assert property ((src_ok && cmd_reg[3:0] == 4'h1) |=> run_out)
		else $error("run bit not applied");
	a_reset_gate: assert property (trip_reset_out |-> $past(mode_ok && cmd_reg[2] && drive_state_in.tripped))
		else $error("trip reset without mode or trip");
	a_speed_limit: assert property (($signed(spd_s) > lim_s) |=> speed_ref_out == $past(speed_limit_in))
		else $error("speed not clamped");
	a_ramp_pair: assert property ($changed(accel_ramp_out) |-> accel_ramp_out == decel_ramp_out
		&& $past(control_mode_in) == 8'h04)
		else $error("ramps not loaded together in mode 4");
	a_ready_bit: assert property ($past(rst_n_in) |-> status_word_out[6] == $past(!drive_state_in.tripped
		&& drive_state_in.hw_enable && !drive_state_in.mains_loss))
		else $error("ready while tripped");
	a_hb_off: assert property ((hb_period_reg == 16'h0)[*2] |-> !heartbeat_out)
		else $error("heartbeat with zero period");
	a_segmented_abort: assert property ((od_req_valid_in && od_req_in.segmented) |=> od_ack_out && od_abort_out)
		else $error("segmented access not aborted");
	a_sync_stage: assert property ((rx_hit[0] && rx_sync[0]) |=> pend_reg[0]
		&& pend_data_reg[0] == $past(rpdo_data_in))
		else $error("sync pdo not staged");

endmodule
`default_nettype wire

// *** bench/master_model.sv ***
`default_nettype none
module master_model
	import fbcmd_pkg::*;
(
	input  wire logic        mclk_in,
	output var  od_req_t     od_req_out,
	output logic             od_req_valid_out,
	input  wire logic        od_ack_in,
	input  wire logic        od_abort_in,
	input  wire logic [31:0] od_rdata_in,
	output logic             rpdo_valid_out,
	output logic             rpdo_sel_out,
	output logic [63:0]      rpdo_data_out,
	output logic             sync_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet network at time zero
	initial begin
		{od_req_valid_out, od_req_out, rpdo_valid_out, rpdo_sel_out, rpdo_data_out, sync_out} = '0;
	end
	// one object access, expedited or segmented as s selects; released request fields are inverted, not left stale
	task automatic sdo(input logic w, s, input logic [15:0] i, input logic [7:0] b, input logic [31:0] d,
		output logic a, output logic [31:0] r);
		@(posedge mclk_in);
		od_req_valid_out <= 1'b1;
		od_req_out <= '{w, s, i, b, d};
		@(posedge mclk_in);
		od_req_valid_out <= 1'b0;
		od_req_out <= ~od_req_out;
		#1;
		a = (od_ack_in === 1'b1) ? od_abort_in : 1'bx;
		r = od_rdata_in;
	endtask
	// one process data frame
	task automatic pdo(input logic s, input logic [63:0] d);
		@(posedge mclk_in);
		rpdo_valid_out <= 1'b1;
		rpdo_sel_out <= s;
		rpdo_data_out <= d;
		@(posedge mclk_in);
		rpdo_valid_out <= 1'b0;
		rpdo_data_out <= ~d;
	endtask
	// one sync message
	task automatic sync();
		@(posedge mclk_in);
		sync_out <= 1'b1;
		@(posedge mclk_in);
		sync_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** bench/fieldbus_drive_command_slave_bench.sv ***
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module fieldbus_drive_command_slave_bench
	import fbcmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] N    = 32'h0000_0005;
	localparam logic [31:0] VEND = 32'h0000_0123; // arbitrary value
	logic         mclk_in, rst_n_in, req_v, ack, abort, rpdo_v, rpdo_sel, sync_p, ab;
	logic         run, fast, coast, trst, hb;
	logic [7:0]   run_source, mode;
	logic [15:0]  limit, spd, acc, dec, stat;
	logic [31:0]  rdata, rd;
	logic [63:0]  rpdo_d;
	logic [1:0]   tpdo;
	drive_state_t ds;
	od_req_t      req;
	int           n_mismatch, num_checks, cyc, n_hb, n_tx;
	logic [55:0]  dflt [18] = '{{16'h1005, 8'h00, 32'h80}, {16'h100c, 8'h00, 32'h0}, {16'h100d, 8'h00, 32'h0},
		{16'h1014, 8'h00, 32'h80 + N}, {16'h1015, 8'h00, 32'h0}, {16'h1017, 8'h00, 32'h0},
		{16'h1018, 8'h00, 32'h4}, {16'h1018, 8'h01, VEND}, {16'h1200, 8'h01, 32'h600 + N},
		{16'h1200, 8'h02, 32'h580 + N}, {16'h1800, 8'h00, 32'h3}, {16'h1800, 8'h01, 32'h4000_0180 + N},
		{16'h1800, 8'h02, 32'hfe}, {16'h1800, 8'h03, 32'h0}, {16'h1801, 8'h01, 32'hc000_0280 + N},
		{16'h1801, 8'h02, 32'h0}, {16'h1600, 8'h01, 32'h2000_0010}, {16'h1600, 8'h04, 32'h0006_0010}};
	logic [15:0]  cmds [5] = '{16'h1, 16'h3, 16'hb, 16'h9, 16'h0};
	logic [2:0]   outs [5] = '{3'b001, 3'b010, 3'b100, 3'b100, 3'b000};

	fieldbus_drive_command_slave #(.HB_UNIT_CYCLES(20), .VENDOR_CODE(VEND)) DUT (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .node_id_in(N[6:0]), .run_source_in(run_source), .control_mode_in(mode),
		.speed_limit_in(limit), .drive_state_in(ds), .od_req_valid_in(req_v), .od_req_in(req),
		.od_ack_out(ack), .od_abort_out(abort), .od_rdata_out(rdata), .rpdo_valid_in(rpdo_v),
		.rpdo_sel_in(rpdo_sel), .rpdo_data_in(rpdo_d), .sync_in(sync_p), .run_out(run), .fast_stop_out(fast),
		.coast_stop_out(coast), .trip_reset_out(trst), .speed_ref_out(spd), .accel_ramp_out(acc),
		.decel_ramp_out(dec), .status_word_out(stat), .tpdo_send_out(tpdo), .heartbeat_out(hb));
	master_model m (.mclk_in(mclk_in), .od_req_out(req), .od_req_valid_out(req_v), .od_ack_in(ack),
		.od_abort_in(abort), .od_rdata_in(rdata), .rpdo_valid_out(rpdo_v), .rpdo_sel_out(rpdo_sel),
		.rpdo_data_out(rpdo_d), .sync_out(sync_p));

	// ****************
	// clock and watchdog
	// ****************
	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc++;
		if (hb === 1'b1) n_hb++;
		if (tpdo[0] === 1'b1) n_tx++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// ****************
	// tasks
	// ****************
	task automatic complete_run();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic do_reset();
		@(posedge mclk_in) rst_n_in <= 1'b0;
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		tick(2);
	endtask
	task automatic rd_chk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
		m.sdo(1'b0, 1'b0, i, s, 32'h0, ab, rd);
		`CHK({ab, rd}, {1'b0, e})
	endtask
	task automatic wr(input logic seg, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic e);
		m.sdo(1'b1, seg, i, s, d, ab, rd);
		`CHK(ab, e)
	endtask
	// speed reference only ever travels in slot 1
	task automatic frame(input logic [15:0] c, input logic [15:0] sp, input logic [15:0] rp);
		m.pdo(1'b0, {16'h0, rp, sp, c});
		tick(2);
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		{rst_n_in, run_source, limit} = {1'b0, 8'h00, 16'h03e8};
		mode = 8'h04;
		ds = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00};
		do_reset();
		foreach (dflt[k]) rd_chk(dflt[k][55:40], dflt[k][39:32], dflt[k][31:0]);
		`CHK(n_hb, 0)
		wr(1'b0, 16'h1017, 8'h00, 32'h3, 1'b0);
		wr(1'b0, 16'h1200, 8'h01, 32'h0, 1'b1);
		wr(1'b0, 16'h1018, 8'h01, 32'h0, 1'b1);
		wr(1'b1, 16'h1017, 8'h00, 32'h5, 1'b1);
		wr(1'b0, 16'h1234, 8'h00, 32'h0, 1'b1);
		rd_chk(16'h1017, 8'h00, 32'h3);
		tick(100);
		n_hb = 0;
		tick(600);
		`CHK(n_hb, 10)
		do_reset();
		foreach (dflt[k]) rd_chk(dflt[k][55:40], dflt[k][39:32], dflt[k][31:0]);
		n_tx = 0;
		frame(16'h0, 16'h0, 16'h0);
		`CHK(n_tx, 1)
		foreach (cmds[k]) begin
			frame(cmds[k], 16'd200, 16'd500);
			`CHK({coast, fast, run}, outs[k])
		end
		`CHK(spd, 16'd200)
		`CHK({acc, dec}, {16'd500, 16'd500})
		@(posedge mclk_in) run_source <= 8'h02;
		frame(16'h1, 16'd200, 16'd500);
		`CHK(run, 1'b0)
		@(posedge mclk_in) {run_source, limit, mode} <= {8'h01, 16'd150, 8'h03};
		frame(16'h1, 16'd300, 16'd700);
		`CHK({run, spd, acc}, {1'b1, 16'd150, 16'd500})
		@(posedge mclk_in) ds <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h2a};
		frame(16'h4, 16'd100, 16'd0);
		`CHK({trst, stat}, {1'b1, 16'h2a03})
		frame(16'h0, 16'd100, 16'd0);
		`CHK(trst, 1'b0)
		@(posedge mclk_in) {mode, ds} <= {8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h2a};
		frame(16'h4, 16'd100, 16'd0);
		`CHK(trst, 1'b0)
		@(posedge mclk_in) ds <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h2a};
		tick(2);
		`CHK(stat, 16'h0060)
		@(posedge mclk_in) ds <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h2a};
		tick(2);
		`CHK(stat, 16'h0020)
		wr(1'b0, 16'h1400, 8'h02, 32'h0, 1'b0);
		frame(16'h1, 16'd100, 16'd0);
		`CHK(run, 1'b0)
		m.sync();
		tick(2);
		`CHK(run, 1'b1)
		// one inhibit unit: the second send must wait at least 100 us
		wr(1'b0, 16'h1800, 8'h03, 32'h1, 1'b0);
		n_tx = 0;
		frame(16'h1, 16'd100, 16'd0);
		frame(16'h1, 16'd100, 16'd0);
		`CHK(n_tx, 1)
		tick(4100);
		`CHK(n_tx, 2)
		complete_run();
	end
endmodule
`default_nettype wire
